// >>> rtl/rpe_pkg.sv
package rpe_pkg;

  localparam int unsigned PIN_N = 7;
  localparam int unsigned SUP_N = 5;

  // Register addresses (full 9-bit map)
  localparam logic [6:0] PAGE_CTRL_LOW7  = 7'h00;
  localparam logic [8:0] A_PIN_LEVELS    = 9'h050;
  localparam logic [8:0] A_SUP_LEVELS    = 9'h051;
  localparam logic [8:0] A_PIN_EVENTS    = 9'h052;
  localparam logic [8:0] A_SUP_EVENTS    = 9'h053;
  localparam logic [8:0] A_PIN_MASKS     = 9'h054;
  localparam logic [8:0] A_SUP_MASKS     = 9'h055;
  localparam logic [8:0] A_LOCK_SLEW_DEB = 9'h056;
  localparam logic [8:0] A_PIN01_CFG     = 9'h058;
  localparam logic [8:0] LOCK_LO         = 9'h0d0;
  localparam logic [8:0] LOCK_HI         = 9'h14f;
  localparam logic [8:0] BASE_MID        = 9'h080;
  localparam logic [8:0] BASE_HIGH       = 9'h100;

  // Page control fields
  localparam int unsigned PG_AUTO_RETURN = 7;
  localparam int unsigned PG_WRITE_MODE  = 6;
  localparam logic [2:0]  PG_LOW         = 3'h0;
  localparam logic [2:0]  PG_MID         = 3'h1;
  localparam logic [2:0]  PG_HIGH        = 3'h2;

  // Lock, slew and debounce fields
  localparam int unsigned CTL_LOCK       = 5;
  localparam int unsigned CTL_SLEW_LSB   = 3;
  localparam logic [7:0]  CTL_WMASK      = 8'h3f;

  // Pin configuration fields, one nibble per pin
  localparam int unsigned PCFG_STRIDE    = 4;
  localparam int unsigned PCFG_POL       = 2;
  localparam int unsigned PCFG_MODE      = 3;
  localparam logic [1:0]  FN_INPUT       = 2'h0;
  localparam logic [1:0]  FN_ALT         = 2'h1;
  localparam logic [1:0]  FN_OPEN_DRAIN  = 2'h2;
  localparam logic [1:0]  FN_PUSH_PULL   = 2'h3;

  localparam logic [7:0]  RESET_ZERO     = 8'h00;

  // Timing at 40 MHz
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned SLEW0_NS       = 4000;
  localparam int unsigned SLEW1_NS       = 2000;
  localparam int unsigned SLEW2_NS       = 1000;
  localparam int unsigned SLEW3_NS       = 500;
  localparam logic [7:0]  SLEW0_CYC = 8'(SLEW0_NS / CLK_PERIOD_NS);
  localparam logic [7:0]  SLEW1_CYC = 8'(SLEW1_NS / CLK_PERIOD_NS);
  localparam logic [7:0]  SLEW2_CYC = 8'(SLEW2_NS / CLK_PERIOD_NS);
  localparam logic [7:0]  SLEW3_CYC = 8'(SLEW3_NS / CLK_PERIOD_NS);
  localparam int unsigned DEB_TICK_NS    = 100000;
  localparam int unsigned DEB_TICK_CYC   = DEB_TICK_NS / CLK_PERIOD_NS;
  // Debounce times in 0.1 ms ticks
  localparam logic [13:0] DEB_T1 = 14'h0001;
  localparam logic [13:0] DEB_T2 = 14'h000a;
  localparam logic [13:0] DEB_T3 = 14'h0064;
  localparam logic [13:0] DEB_T4 = 14'h01f4;
  localparam logic [13:0] DEB_T5 = 14'h09c4;
  localparam logic [13:0] DEB_T6 = 14'h1388;
  localparam logic [13:0] DEB_T7 = 14'h2710;

endpackage

// >>> rtl/rpe_regs.sv
// Behaviour
// - With auto-return set, page select goes to zero when an access ends, unless that access wrote the page register.
// - Two-wire write mode bit: 0 page write, 1 repeated; ignored on four-wire.
// - Two-wire: page 00x reaches 0x00-0xFF, page 01x reaches 0x100-0x17F.
// - Four-wire: page 0,1,2 reach 0x00, 0x80, 0x100 blocks; higher is reserved.
// - Status reads show live levels; pin levels 0..6 in bits 0..6.
// - Status bits keep the polarity of their signals.
// - Status bit 4 set while configured voltage is at or above maximum.
// - Bit 3 shows thermal shutdown, bit 2 thermal warning.
// - Bit 1 shows output out of range, bit 0 overcurrent.
// - In interrupt mode any status change sets its event bit.
// - Interrupt asserted while any unmasked event bit is set.
// - An event arriving during a clearing write is still latched.
// - Dedicated mode drives alarm port from status with selectable polarity.
// - Dedicated mode raises events only on inactive-to-active edges.
// - Each event bit has a mask bit that keeps it off the outputs.
// - Write lock blocks writes to 0xD0-0x14F except to the page register at 0x100; unlocked they pass.
// - Slew code sets one step every 4.0, 2.0, 1.0 or 0.5 us.
// - Debounce code selects none up to 1000 ms for filtered inputs.
// - Pin function: input, alternate, open-drain, push-pull; polarity and mode bits.
`timescale 1ns/1ps
`default_nettype none
module rpe_regs #(
  parameter int unsigned P_TICK_CYC = rpe_pkg::DEB_TICK_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_four_wire,
  input  wire logic       i_acc_valid,
  input  wire logic       i_acc_write,
  input  wire logic [7:0] i_acc_addr,
  input  wire logic [7:0] i_acc_wdata,
  input  wire logic       i_acc_end,
  output logic      [7:0] o_acc_rdata,
  output logic      [8:0] o_ext_addr,
  output logic            o_ext_wr,
  input  wire logic [7:0] i_ext_rdata,
  output logic            o_repeated_write,
  input  wire logic [6:0] i_general_input,
  input  wire logic       i_overcurrent_flag,
  input  wire logic       i_output_out_of_range,
  input  wire logic       i_thermal_warning,
  input  wire logic       i_thermal_shutdown_flag,
  input  wire logic [6:0] i_vbuck_config,
  input  wire logic [6:0] i_max_voltage_setting,
  input  wire logic       i_alarm_irq_mode,
  input  wire logic       i_alarm_active_high,
  input  wire logic       i_voltage_ramping,
  output logic            o_ramp_step,
  output logic            o_interrupt_out_low,
  output logic            o_alarm_port,
  output logic      [1:0] o_general_output,
  output logic      [1:0] o_general_output_oe,
  output logic      [1:0] o_pin_alt_sel
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0]       page;
    logic             page_written;
    logic [6:0]       ev_a;
    logic [4:0]       ev_b;
    logic [6:0]       m_a;
    logic [4:0]       m_b;
    logic [7:0]       ctl;
    logic [7:0]       pcfg;
    logic [6:0]       gpi_s1;
    logic [6:0]       gpi_s2;
    logic [3:0]       sup_s1;
    logic [3:0]       sup_s2;
    logic [6:0]       pin_lvl;
    logic [6:0]       pin_prev;
    logic [4:0]       sup_lvl;
    logic [4:0]       sup_prev;
    logic [11:0]      tick_cnt;
    logic             tick;
    logic [6:0][13:0] deb_cnt;
    logic [7:0]       slew_cnt;
    logic             ramp_step;
    logic [7:0]       rdata;
  } rpe_state_s;

  rpe_state_s st;
  rpe_state_s next_st;

  logic [9:0]  mapped;
  logic [8:0]  full_addr;
  logic        addr_ok;
  logic        locked;
  logic        local_hit;
  logic [6:0]  pin_pol;
  logic [6:0]  deb_en;
  logic [6:0]  new_a;
  logic [4:0]  new_b;
  logic [6:0]  clr_a;
  logic [4:0]  clr_b;
  logic [7:0]  rd_local;
  logic        irq;
  logic        ded;

  ////////////////////////////////////////////////////////////////////////////
  // Returns {valid, address}
  function automatic logic [9:0] map_addr(input logic       four,
                                          input logic [2:0] pg,
                                          input logic [7:0] a);
    logic [9:0] r;
    r = {1'b0, 9'h000};
    if (four)
    begin
      case (pg)
        rpe_pkg::PG_LOW:  r = {1'b1, 2'b00, a[6:0]};
        rpe_pkg::PG_MID:  r = {1'b1, rpe_pkg::BASE_MID | {2'b00, a[6:0]}};
        rpe_pkg::PG_HIGH: r = {1'b1, rpe_pkg::BASE_HIGH | {2'b00, a[6:0]}};
        default:          r = {1'b0, 9'h000};
      endcase
    end
    else if (pg[2] == 1'b0)
    begin
      if (pg[1] == 1'b0)
        r = {1'b1, 1'b0, a};
      else
        r = {~a[7], rpe_pkg::BASE_HIGH | {2'b00, a[6:0]}};
    end
    return r;
  endfunction

  function automatic logic [13:0] deb_ticks(input logic [2:0] code);
    logic [13:0] t;
    case (code)
      3'h1:    t = rpe_pkg::DEB_T1;
      3'h2:    t = rpe_pkg::DEB_T2;
      3'h3:    t = rpe_pkg::DEB_T3;
      3'h4:    t = rpe_pkg::DEB_T4;
      3'h5:    t = rpe_pkg::DEB_T5;
      3'h6:    t = rpe_pkg::DEB_T6;
      3'h7:    t = rpe_pkg::DEB_T7;
      default: t = rpe_pkg::DEB_T1;
    endcase
    return t;
  endfunction

  function automatic logic [7:0] slew_cycles(input logic [1:0] code);
    logic [7:0] c;
    case (code)
      2'h0:    c = rpe_pkg::SLEW0_CYC;
      2'h1:    c = rpe_pkg::SLEW1_CYC;
      2'h2:    c = rpe_pkg::SLEW2_CYC;
      default: c = rpe_pkg::SLEW3_CYC;
    endcase
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st   = st;
    mapped    = map_addr(i_four_wire, st.page[2:0], i_acc_addr);
    full_addr = mapped[8:0];
    addr_ok   = mapped[9];
    locked    = st.ctl[rpe_pkg::CTL_LOCK] && full_addr >= rpe_pkg::LOCK_LO
                && full_addr <= rpe_pkg::LOCK_HI;
    local_hit = (full_addr[6:0] == rpe_pkg::PAGE_CTRL_LOW7)
                || (full_addr >= rpe_pkg::A_PIN_LEVELS
                    && full_addr <= rpe_pkg::A_LOCK_SLEW_DEB)
                || (full_addr == rpe_pkg::A_PIN01_CFG);

    // Input synchronisers; status keeps signal polarity
    next_st.gpi_s1   = i_general_input;
    next_st.gpi_s2   = st.gpi_s1;
    next_st.sup_s1   = {i_thermal_shutdown_flag, i_thermal_warning,
                        i_output_out_of_range, i_overcurrent_flag};
    next_st.sup_s2   = st.sup_s1;
    next_st.sup_lvl  = {(i_vbuck_config >= i_max_voltage_setting),
                        st.sup_s2};
    next_st.sup_prev = st.sup_lvl;
    next_st.pin_prev = st.pin_lvl;

    // Debounce time base
    next_st.tick = 1'b0;
    if (st.tick_cnt == 12'(P_TICK_CYC - 1))
    begin
      next_st.tick_cnt = 12'h000;
      next_st.tick     = 1'b1;
    end
    else
    begin
      next_st.tick_cnt = st.tick_cnt + 12'h001;
    end

    // Only pins 0 and 1 have their configuration in this block
    pin_pol = 7'h7c;
    deb_en  = 7'h00;
    for (int i = 0; i < 2; i++)
    begin
      pin_pol[i] = st.pcfg[i*rpe_pkg::PCFG_STRIDE + rpe_pkg::PCFG_POL];
      deb_en[i]  = st.pcfg[i*rpe_pkg::PCFG_STRIDE + rpe_pkg::PCFG_MODE]
                   && st.pcfg[i*rpe_pkg::PCFG_STRIDE +: 2] == rpe_pkg::FN_INPUT
                   && st.ctl[2:0] != 3'h0;
    end

    for (int i = 0; i < rpe_pkg::PIN_N; i++)
    begin
      if (!deb_en[i])
      begin
        next_st.pin_lvl[i] = st.gpi_s2[i];
        next_st.deb_cnt[i] = 14'h0000;
      end
      else if (st.gpi_s2[i] == st.pin_lvl[i])
      begin
        next_st.deb_cnt[i] = 14'h0000;
      end
      else if (st.tick)
      begin
        if (st.deb_cnt[i] + 14'h0001 >= deb_ticks(st.ctl[2:0]))
        begin
          next_st.pin_lvl[i] = st.gpi_s2[i];
          next_st.deb_cnt[i] = 14'h0000;
        end
        else
        begin
          next_st.deb_cnt[i] = st.deb_cnt[i] + 14'h0001;
        end
      end
    end

    // Voltage ramp step strobe
    next_st.ramp_step = 1'b0;
    if (!i_voltage_ramping)
    begin
      next_st.slew_cnt = 8'h00;
    end
    else if (st.slew_cnt >= slew_cycles(st.ctl[rpe_pkg::CTL_SLEW_LSB +: 2]) - 8'h01)
    begin
      next_st.slew_cnt  = 8'h00;
      next_st.ramp_step = 1'b1;
    end
    else
    begin
      next_st.slew_cnt = st.slew_cnt + 8'h01;
    end

    // Event detection: any change, or activation edge in dedicated mode
    if (i_alarm_irq_mode)
    begin
      new_a = st.pin_lvl ^ st.pin_prev;
      new_b = st.sup_lvl ^ st.sup_prev;
    end
    else
    begin
      new_a = ~(st.pin_lvl ^ pin_pol) & (st.pin_prev ^ pin_pol);
      new_b = st.sup_lvl & ~st.sup_prev;
    end

    // Write-one-to-clear; a new event wins over the clear
    clr_a = 7'h00;
    clr_b = 5'h00;
    if (i_acc_valid && i_acc_write && addr_ok)
    begin
      if (full_addr == rpe_pkg::A_PIN_EVENTS)
        clr_a = i_acc_wdata[6:0];
      if (full_addr == rpe_pkg::A_SUP_EVENTS)
        clr_b = i_acc_wdata[4:0];
      if (full_addr[6:0] == rpe_pkg::PAGE_CTRL_LOW7)
        next_st.page = i_acc_wdata;
      if (full_addr == rpe_pkg::A_PIN_MASKS)
        next_st.m_a = i_acc_wdata[6:0];
      if (full_addr == rpe_pkg::A_SUP_MASKS)
        next_st.m_b = i_acc_wdata[4:0];
      if (full_addr == rpe_pkg::A_LOCK_SLEW_DEB)
        next_st.ctl = i_acc_wdata & rpe_pkg::CTL_WMASK;
      if (full_addr == rpe_pkg::A_PIN01_CFG)
        next_st.pcfg = i_acc_wdata;
    end
    next_st.ev_a = (st.ev_a & ~clr_a) | new_a;
    next_st.ev_b = (st.ev_b & ~clr_b) | new_b;

    // Auto-return of the page select at the end of an access
    next_st.page_written = st.page_written;
    if (i_acc_end)
    begin
      next_st.page_written = 1'b0;
      if (st.page[rpe_pkg::PG_AUTO_RETURN] && !st.page_written)
        next_st.page[2:0] = rpe_pkg::PG_LOW;
    end
    if (i_acc_valid && i_acc_write && addr_ok
        && full_addr[6:0] == rpe_pkg::PAGE_CTRL_LOW7)
    begin
      next_st.page         = i_acc_wdata;
      next_st.page_written = 1'b1;
    end

    // Read data
    case (full_addr)
      rpe_pkg::A_PIN_LEVELS:    rd_local = {1'b0, st.pin_lvl};
      rpe_pkg::A_SUP_LEVELS:    rd_local = {3'h0, st.sup_lvl};
      rpe_pkg::A_PIN_EVENTS:    rd_local = {1'b0, st.ev_a};
      rpe_pkg::A_SUP_EVENTS:    rd_local = {3'h0, st.ev_b};
      rpe_pkg::A_PIN_MASKS:     rd_local = {1'b0, st.m_a};
      rpe_pkg::A_SUP_MASKS:     rd_local = {3'h0, st.m_b};
      rpe_pkg::A_LOCK_SLEW_DEB: rd_local = st.ctl;
      rpe_pkg::A_PIN01_CFG:     rd_local = st.pcfg;
      default:                  rd_local = st.page;
    endcase
    if (i_acc_valid && !i_acc_write)
    begin
      if (!addr_ok)
        next_st.rdata = rpe_pkg::RESET_ZERO;
      else if (local_hit)
        next_st.rdata = rd_local;
      else
        next_st.rdata = i_ext_rdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      st <= '0;
    else
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign irq = |(st.ev_a & ~st.m_a) || |(st.ev_b & ~st.m_b);
  assign ded = |(st.sup_lvl & ~st.m_b);
  assign o_interrupt_out_low = ~irq;
  assign o_alarm_port = i_alarm_irq_mode ? ~irq : (ded ~^ i_alarm_active_high);
  assign o_acc_rdata = st.rdata;
  assign o_ext_addr  = full_addr;
  assign o_ext_wr    = i_acc_valid && i_acc_write && addr_ok && !local_hit
                       && !locked;
  assign o_repeated_write = !i_four_wire && st.page[rpe_pkg::PG_WRITE_MODE];
  assign o_ramp_step = st.ramp_step;

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      o_general_output[i]    = 1'b0;
      o_general_output_oe[i] = 1'b0;
      o_pin_alt_sel[i]       = 1'b0;
      case (st.pcfg[i*rpe_pkg::PCFG_STRIDE +: 2])
        rpe_pkg::FN_PUSH_PULL:
        begin
          o_general_output[i]    = st.pcfg[i*rpe_pkg::PCFG_STRIDE + rpe_pkg::PCFG_MODE];
          o_general_output_oe[i] = 1'b1;
        end
        rpe_pkg::FN_OPEN_DRAIN:
          o_general_output_oe[i] = ~st.pcfg[i*rpe_pkg::PCFG_STRIDE + rpe_pkg::PCFG_MODE];
        rpe_pkg::FN_ALT:
          o_pin_alt_sel[i] = 1'b1;
        default:
          o_pin_alt_sel[i] = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  sequence seq_auto_return;
    st.page[rpe_pkg::PG_AUTO_RETURN] && i_acc_end && !st.page_written
    && !(i_acc_valid && i_acc_write);
  endsequence
  sequence seq_oc_held;
    i_overcurrent_flag [*3];
  endsequence

  page_return_a: assert property (seq_auto_return |=> st.page[2:0] == 3'h0)
    else $error("page select did not return to zero");
  four_wire_mode_a: assert property (i_four_wire |-> !o_repeated_write)
    else $error("write mode active on four-wire");
  two_wire_map_a: assert property (!i_four_wire && st.page[2:1] == 2'b01
      && !i_acc_addr[7] |-> o_ext_addr == {2'b10, i_acc_addr[6:0]})
    else $error("two-wire upper page mapped wrong");
  four_wire_map_a: assert property (i_four_wire && st.page[2:0] == 3'h1
      |-> o_ext_addr == {2'b01, i_acc_addr[6:0]})
    else $error("four-wire middle page mapped wrong");
  overcurrent_level_a: assert property (seq_oc_held |=> st.sup_lvl[0])
    else $error("overcurrent status not shown");
  over_max_a: assert property (i_vbuck_config >= i_max_voltage_setting
      |=> st.sup_lvl[4])
    else $error("over-max status not set");
  event_latch_a: assert property (new_b[1] |=> st.ev_b[1])
    else $error("event lost during clear");
  rising_only_a: assert property (!i_alarm_irq_mode && st.sup_prev[2]
      && !st.sup_lvl[2] && !st.ev_b[2] |=> !st.ev_b[2])
    else $error("event on falling edge in dedicated mode");
  unmasked_irq_a: assert property (st.ev_b[0] && !st.m_b[0]
      |-> !o_interrupt_out_low)
    else $error("unmasked event without interrupt");
  irq_release_a: assert property ((st.ev_a & ~st.m_a) == 7'h00
      && (st.ev_b & ~st.m_b) == 5'h00 |-> o_interrupt_out_low)
    else $error("interrupt held without unmasked event");
  lock_block_a: assert property (i_acc_valid && i_acc_write && locked
      |-> !o_ext_wr)
    else $error("locked write passed");
  slew_fast_a: assert property (o_ramp_step && st.ctl[4:3] == 2'h3
      && i_voltage_ramping |-> st.slew_cnt == 8'h00)
    else $error("ramp step timing wrong");

endmodule
`default_nettype wire

// >>> sim/rpe_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rpe_host_model (
  input  wire logic       i_clk,
  output logic            o_acc_valid,
  output logic            o_acc_write,
  output logic      [7:0] o_acc_addr,
  output logic      [7:0] o_acc_wdata,
  output logic            o_acc_end,
  input  wire logic [7:0] i_acc_rdata,
  input  wire logic [8:0] i_ext_addr,
  input  wire logic       i_ext_wr
);
  logic [8:0] last_addr;
  logic       last_wr;
  logic [7:0] last_rd;

  initial
  begin
    o_acc_valid = 1'b0;
    o_acc_write = 1'b0;
    o_acc_addr  = 8'h00;
    o_acc_wdata = 8'h00;
    o_acc_end   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One byte; qualifiers are flipped once released so stale values never match
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_acc_valid = 1'b1;
    o_acc_write = wr;
    o_acc_addr  = a;
    o_acc_wdata = d;
    #20;
    last_addr = i_ext_addr;
    last_wr   = i_ext_wr;
    @(posedge i_clk);
    #1;
    o_acc_valid = 1'b0;
    o_acc_write = ~wr;
    o_acc_addr  = ~a;
    o_acc_wdata = ~d;
    last_rd     = i_acc_rdata;
  endtask

  task automatic finish_txn();
    @(posedge i_clk);
    #1;
    o_acc_end = 1'b1;
    @(posedge i_clk);
    #1;
    o_acc_end = 1'b0;
  endtask

  // Event register is cleared by writing back what was read
  task automatic clear_events(input logic [7:0] a);
    access(1'b0, a, 8'h00);
    access(1'b1, a, last_rd);
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_regulator_ctrl_page_event_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_regulator_ctrl_page_event_regs;
  logic       i_clk;
  logic       i_reset_n;
  logic       four_wire;
  logic [6:0] gin;
  logic       oc, oor, warn, crit;
  logic [6:0] vbuck, over_max_voltage;
  logic       irq_mode, act_high, ramping;
  logic       valid, wr, acc_end, ext_wr, rep_wr, step, irq_n, alarm;
  logic [7:0] addr, wdata, rdata;
  logic [8:0] ext_addr;
  logic [1:0] gout, goe, galt;
  logic [7:0] ext_rd;
  int         errors;
  int         tests_run;
  int         n;

  // Outside registers answer with a pattern of their own address
  assign ext_rd = ext_addr[7:0] ^ 8'h5a;

  always #12.5 i_clk = ~i_clk;

  rpe_host_model host_u (.i_clk(i_clk), .o_acc_valid(valid), .o_acc_write(wr),
    .o_acc_addr(addr), .o_acc_wdata(wdata), .o_acc_end(acc_end), .i_acc_rdata(rdata),
    .i_ext_addr(ext_addr), .i_ext_wr(ext_wr));

  rpe_regs #(.P_TICK_CYC(4)) dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_four_wire(four_wire), .i_acc_valid(valid), .i_acc_write(wr), .i_acc_addr(addr),
    .i_acc_wdata(wdata), .i_acc_end(acc_end), .o_acc_rdata(rdata), .o_ext_addr(ext_addr),
    .o_ext_wr(ext_wr), .i_ext_rdata(ext_rd), .o_repeated_write(rep_wr),
    .i_general_input(gin), .i_overcurrent_flag(oc), .i_output_out_of_range(oor),
    .i_thermal_warning(warn), .i_thermal_shutdown_flag(crit), .i_vbuck_config(vbuck),
    .i_max_voltage_setting(over_max_voltage), .i_alarm_irq_mode(irq_mode),
    .i_alarm_active_high(act_high), .i_voltage_ramping(ramping), .o_ramp_step(step),
    .o_interrupt_out_low(irq_n), .o_alarm_port(alarm), .o_general_output(gout),
    .o_general_output_oe(goe), .o_pin_alt_sel(galt));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [8:0] exp, input string nm);
    host_u.access(1'b0, a, 8'h00);
    chk(nm, exp, {1'b0, host_u.last_rd});
  endtask

  task automatic final_report();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] ra [7];
    ra = '{8'h00, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h58};
    foreach (ra[i])
      rd(ra[i], 9'h000, "reset value");
    chk("irq_n idle", 9'h001, {8'h00, irq_n});
  endtask

  task automatic t_status();
    gin = 7'h55;
    oc = 1'b1;
    warn = 1'b1;
    vbuck = 7'h20;
    over_max_voltage = 7'h20;
    cyc(6);
    rd(8'h50, 9'h055, "pin levels");
    rd(8'h51, 9'h015, "sup levels at max");
    vbuck = 7'h1f;
    cyc(6);
    rd(8'h51, 9'h005, "sup levels below max");
    {oor, crit, oc, warn} = 4'b1100;
    cyc(6);
    rd(8'h51, 9'h00a, "sup levels swapped");
    {oor, crit, oc, warn} = 4'b0011;
    cyc(6);
  endtask

  task automatic t_events();
    rd(8'h52, 9'h055, "pin events");
    rd(8'h53, 9'h01f, "sup events");
    chk("irq_n set", 9'h000, {8'h00, irq_n});
    host_u.access(1'b1, 8'h54, 8'h7f);
    host_u.access(1'b1, 8'h55, 8'h1f);
    chk("irq_n masked", 9'h001, {8'h00, irq_n});
    host_u.access(1'b1, 8'h55, 8'h00);
    chk("irq_n unmask", 9'h000, {8'h00, irq_n});
    host_u.clear_events(8'h53);
    rd(8'h53, 9'h000, "sup events cleared");
    chk("irq_n cleared", 9'h001, {8'h00, irq_n});
    host_u.access(1'b1, 8'h54, 8'h00);
    chk("irq_n pin unmask", 9'h000, {8'h00, irq_n});
    gin = 7'h54;
    host_u.clear_events(8'h52);
    cyc(6);
    rd(8'h52, 9'h001, "event during clear");
    host_u.access(1'b1, 8'h52, 8'hff);
    chk("irq_n none left", 9'h001, {8'h00, irq_n});
  endtask

  task automatic t_dedicated();
    irq_mode = 1'b0;
    cyc(2);
    chk("alarm active high", 9'h001, {8'h00, alarm});
    {oc, warn} = 2'b00;
    cyc(6);
    chk("alarm idle", 9'h000, {8'h00, alarm});
    rd(8'h53, 9'h000, "no event on fall");
    oc = 1'b1;
    cyc(6);
    rd(8'h53, 9'h001, "event on rise");
    act_high = 1'b0;
    cyc(1);
    chk("alarm active low", 9'h000, {8'h00, alarm});
    host_u.access(1'b1, 8'h55, 8'h01);
    chk("alarm masked", 9'h001, {8'h00, alarm});
    host_u.access(1'b1, 8'h55, 8'h00);
    host_u.access(1'b1, 8'h53, 8'hff);
    irq_mode = 1'b1;
    act_high = 1'b1;
  endtask

  task automatic t_pages();
    host_u.access(1'b1, 8'h00, 8'h02);
    rd(8'h05, 9'h05f, "outside read");
    chk("map 01x", 9'h105, host_u.last_addr);
    rd(8'h85, 9'h000, "unmapped read");
    host_u.access(1'b1, 8'h00, 8'h41);
    host_u.access(1'b0, 8'hc3, 8'h00);
    chk("map 00x", 9'h0c3, host_u.last_addr);
    chk("repeated write", 9'h001, {8'h00, rep_wr});
    four_wire = 1'b1;
    cyc(1);
    chk("repeated four-wire", 9'h000, {8'h00, rep_wr});
    host_u.access(1'b0, 8'h10, 8'h00);
    chk("map page 1", 9'h090, host_u.last_addr);
    host_u.access(1'b1, 8'h00, 8'h02);
    host_u.access(1'b0, 8'h10, 8'h00);
    chk("map page 2", 9'h110, host_u.last_addr);
    host_u.access(1'b1, 8'h00, 8'h81);
    host_u.finish_txn();
    host_u.access(1'b0, 8'h10, 8'h00);
    chk("kept over own end", 9'h090, host_u.last_addr);
    host_u.finish_txn();
    host_u.access(1'b0, 8'h10, 8'h00);
    chk("returned page", 9'h010, host_u.last_addr);
    rd(8'h00, 9'h080, "page after return");
    host_u.access(1'b1, 8'h00, 8'h00);
    four_wire = 1'b0;
  endtask

  task automatic t_lock();
    host_u.access(1'b1, 8'h56, 8'hff);
    rd(8'h56, 9'h03f, "control bits");
    four_wire = 1'b1;
    host_u.access(1'b1, 8'h00, 8'h01);
    host_u.access(1'b1, 8'h50, 8'h00);
    chk("locked low edge", 9'h000, {8'h00, host_u.last_wr});
    host_u.access(1'b1, 8'h4f, 8'h00);
    chk("below lock", 9'h001, {8'h00, host_u.last_wr});
    host_u.access(1'b1, 8'h00, 8'h02);
    host_u.access(1'b1, 8'h4f, 8'h00);
    chk("locked high edge", 9'h000, {8'h00, host_u.last_wr});
    host_u.access(1'b1, 8'h50, 8'h00);
    chk("above lock", 9'h001, {8'h00, host_u.last_wr});
    host_u.access(1'b1, 8'h00, 8'h00);
    host_u.access(1'b1, 8'h56, 8'h00);
    host_u.access(1'b1, 8'h00, 8'h01);
    host_u.access(1'b1, 8'h50, 8'h00);
    chk("unlocked", 9'h001, {8'h00, host_u.last_wr});
    host_u.access(1'b1, 8'h00, 8'h00);
    four_wire = 1'b0;
  endtask

  task automatic t_slew();
    for (int code = 0; code < 4; code++)
    begin
      host_u.access(1'b1, 8'h56, 8'(code << 3));
      ramping = 1'b1;
      n = 0;
      while (step !== 1'b1 && n < 400)
      begin
        cyc(1);
        n++;
      end
      n = 0;
      do
      begin
        cyc(1);
        n++;
      end while (step !== 1'b1 && n < 400);
      chk("ramp interval", 9'((4000 >> code) / 25), 9'(n));
      ramping = 1'b0;
      cyc(2);
    end
  endtask

  task automatic t_pins();
    logic [7:0] cfg [3];
    logic [3:0] oa [3];
    logic [1:0] om [3];
    logic [1:0] ov [3];
    cfg = '{8'h00, 8'h1b, 8'h3a};
    oa = '{4'h0, 4'h6, 4'h8};
    om = '{2'h0, 2'h1, 2'h2};
    ov = '{2'h0, 2'h1, 2'h0};
    foreach (cfg[i])
    begin
      host_u.access(1'b1, 8'h58, cfg[i]);
      chk("pin oe alt", {5'h00, oa[i]}, {5'h00, goe, galt});
      chk("pin level", {7'h00, ov[i]}, {7'h00, gout & om[i]});
    end
    host_u.access(1'b1, 8'h58, 8'h08);
    host_u.access(1'b1, 8'h56, 8'h03);
    gin = 7'h55;
    cyc(20);
    rd(8'h50, 9'h054, "filtered early");
    cyc(450);
    rd(8'h50, 9'h055, "filtered late");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    errors = 0;
    tests_run = 0;
    i_clk = 1'b0;
    i_reset_n = 1'b0;
    four_wire = 1'b0;
    gin = 7'h00;
    {oc, oor, warn, crit} = 4'b0000;
    vbuck = 7'h00;
    over_max_voltage = 7'h7f;
    irq_mode = 1'b1;
    act_high = 1'b1;
    ramping = 1'b0;
    cyc(16);
    i_reset_n = 1'b1;
    t_reset();
    t_status();
    t_events();
    t_dedicated();
    t_pages();
    t_lock();
    t_slew();
    t_pins();
    final_report();
  end

  initial
  begin
    #(25 * 20000);
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
